// File: src/srcfg_map.vh
// Constants for the serializer reset and configuration register bank.
// Assumes an I2C slave engine outside presents byte-wide register accesses.
`ifndef SRCFG_MAP_VH
`define SRCFG_MAP_VH
`define SRCFG_ADDR_RESET 8'h01
`define SRCFG_ADDR_GENCFG 8'h03
`define SRCFG_GENCFG_RST 8'hD2
`define SRCFG_GENCFG_WMASK 8'hBF
`define SRCFG_RESET_WMASK 8'h13
`define SRCFG_BIT_RST_LOGIC 0
`define SRCFG_BIT_RST_FULL 1
`define SRCFG_BIT_RST_VIDEO 4
`define SRCFG_BIT_CRC_EN 7
`define SRCFG_BIT_AUTOACK 5
`define SRCFG_RST_PULSE_CYC 4
`endif

// File: src/srcfg_rst_pulse.v
// Stretches a one-cycle reset request into a fixed-length reset pulse.
// Assumes request and clock in the same domain.
`timescale 1ns/1ns
`default_nettype none
module srcfg_rst_pulse #(
  parameter LEN = 4
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire req_i,
  output reg active_o
);
  reg [7:0] cnt_ff;
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 8'h00;
      active_o <= 1'b0;
    end else if (req_i) begin
      cnt_ff <= LEN[7:0];
      active_o <= 1'b1;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
      active_o <= (cnt_ff != 8'h01);
    end else begin
      active_o <= 1'b0;
    end
  end
endmodule // srcfg_rst_pulse
`default_nettype wire

// File: src/srcfg_regs.v
// Reset and general configuration registers of the serializer.
// Assumes the I2C slave engine drives addr/wdata/wr_en/rd_en in this clock domain,
// and remote I2C forwarding reports its acknowledge on remote_ack_*.
// Logic and video resets leave as active-low levels, the restore and strap strobes as high pulses; the blocks they reset sit elsewhere.
// Strap capture and the listed default registers live outside and act on strobes.
`include "srcfg_map.vh"
`timescale 1ns/1ns
`default_nettype none
module srcfg_regs #(
  parameter RST_PULSE_CYC = `SRCFG_RST_PULSE_CYC
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_en_i,
  input wire rd_en_i,
  input wire second_port_select_i,
  input wire pass_all_p0_i,
  input wire pass_all_p1_i,
  input wire remote_wr_p0_i,
  input wire remote_wr_p1_i,
  input wire remote_tgt_is_deser_i,
  input wire remote_ack_p0_i,
  input wire remote_ack_p1_i,
  output reg [7:0] rdata_o,
  output reg crc_check_en_o,
  output reg autoack_p0_o,
  output reg autoack_p1_o,
  output reg local_ack_p0_o,
  output reg local_ack_p1_o,
  output reg logic_reset_n_o,
  output reg video_reset_n_o,
  output reg restore_defaults_o,
  output reg strap_reload_o
);

  ////////////////////////////////////////////////////////////////////////
  // Register state
  reg [7:0] gencfg_p0_ff;
  reg [7:0] gencfg_p1_ff;
  reg full_req_ff;
  reg [7:0] nxt_gencfg_p0;
  reg [7:0] nxt_gencfg_p1;
  wire logic_active;
  wire video_active;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  // Byte-wide address compare, shared by the write and read decode
  function addr_hit;
    input [7:0] addr_v;
    input [7:0] target_v;
    begin
      addr_hit = (addr_v == target_v);
    end
  endfunction

  // Reserved reset bits are dropped before decoding
  wire [7:0] rst_wbits = wdata_i & `SRCFG_RESET_WMASK;
  wire wr_reset = wr_en_i && addr_hit(addr_i, `SRCFG_ADDR_RESET);
  wire wr_gencfg = wr_en_i && addr_hit(addr_i, `SRCFG_ADDR_GENCFG);
  wire rd_gencfg = rd_en_i && addr_hit(addr_i, `SRCFG_ADDR_GENCFG);
  wire req_full = wr_reset && rst_wbits[`SRCFG_BIT_RST_FULL];
  wire req_logic = wr_reset && rst_wbits[`SRCFG_BIT_RST_LOGIC];
  wire req_video = wr_reset && rst_wbits[`SRCFG_BIT_RST_VIDEO];

  ////////////////////////////////////////////////////////////////////////
  // Reset stretchers
  // Full reset is delayed one cycle so the write itself completes first.
  // The register copies see it for one edge only, which is enough since
  // they hold no multi-cycle state of their own.
  wire regs_rst = !rst_n_i || full_req_ff;

  srcfg_rst_pulse #(.LEN(RST_PULSE_CYC)) u_logic_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(req_logic || full_req_ff),
    .active_o(logic_active)
  );

  // Video receiver has its own stretcher so bit 4 leaves the rest running
  srcfg_rst_pulse #(.LEN(RST_PULSE_CYC)) u_video_pulse (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .req_i(req_video || full_req_ff),
    .active_o(video_active)
  );

  // Masked merge keeps stored bits where the mask is clear
  function [7:0] merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    begin
      merge = (old_v & ~mask) | (new_v & mask);
    end
  endfunction

  always @* begin
    nxt_gencfg_p0 = gencfg_p0_ff;
    nxt_gencfg_p1 = gencfg_p1_ff;
    // Port select steers the write to that port's own copy
    if (wr_gencfg && !second_port_select_i) begin
      nxt_gencfg_p0 = merge(gencfg_p0_ff, wdata_i, `SRCFG_GENCFG_WMASK);
    end
    if (wr_gencfg && second_port_select_i) begin
      nxt_gencfg_p1 = merge(gencfg_p1_ff, wdata_i, `SRCFG_GENCFG_WMASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and self-clearing reset bits
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      full_req_ff <= 1'b0;
    end else begin
      // Single-cycle request; the self-clearing bit has no storage
      full_req_ff <= req_full;
    end
  end

  // A full reset returns both port copies to their reset value
  always @(posedge clk_sys_i) begin
    if (regs_rst) begin
      gencfg_p0_ff <= `SRCFG_GENCFG_RST;
      gencfg_p1_ff <= `SRCFG_GENCFG_RST;
    end else begin
      gencfg_p0_ff <= nxt_gencfg_p0;
      gencfg_p1_ff <= nxt_gencfg_p1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  // Two ports, kept as two-bit vectors so the ack path is written once
  localparam NPORT = 2;

  wire [NPORT-1:0] cfg_autoack = {gencfg_p1_ff[`SRCFG_BIT_AUTOACK], gencfg_p0_ff[`SRCFG_BIT_AUTOACK]};
  wire [NPORT-1:0] pass_all = {pass_all_p1_i, pass_all_p0_i};
  wire [NPORT-1:0] remote_wr = {remote_wr_p1_i, remote_wr_p0_i};
  wire [NPORT-1:0] remote_ack = {remote_ack_p1_i, remote_ack_p0_i};
  wire [NPORT-1:0] aa;
  wire [NPORT-1:0] imm;
  wire [NPORT-1:0] nxt_local_ack;

  genvar port_g;
  generate
    for (port_g = 0; port_g < NPORT; port_g = port_g + 1) begin : g_port
      // Each port works from its own copy, so the settings never mix
      // Auto-ack is held off while the registers sit in reset
      assign aa[port_g] = cfg_autoack[port_g] && !regs_rst;
      // Auto-ack covers the deserializer, or any target under pass-all
      assign imm[port_g] = aa[port_g] && (remote_tgt_is_deser_i || pass_all[port_g]);
      // Remote NACK is masked while immediate ack applies
      assign nxt_local_ack[port_g] = remote_wr[port_g] && (imm[port_g] || remote_ack[port_g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_gencfg) begin
      // Reserved bit 6 is stored but never shown
      rdata_o <= second_port_select_i ? (gencfg_p1_ff & `SRCFG_GENCFG_WMASK)
                                      : (gencfg_p0_ff & `SRCFG_GENCFG_WMASK);
    end else if (rd_en_i) begin
      // Reset bits always read zero: they clear on their own
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration outputs
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      crc_check_en_o <= 1'b1;
      autoack_p0_o <= 1'b0;
      autoack_p1_o <= 1'b0;
    end else begin
      // Checker follows the port 0 copy; forced on during a full reset
      crc_check_en_o <= regs_rst ? 1'b1 : gencfg_p0_ff[`SRCFG_BIT_CRC_EN];
      autoack_p0_o <= aa[0];
      autoack_p1_o <= aa[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Acknowledge towards the local I2C master
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      local_ack_p0_o <= 1'b0;
      local_ack_p1_o <= 1'b0;
    end else begin
      // One edge after the remote answer, as the slave engine expects
      local_ack_p0_o <= nxt_local_ack[0];
      local_ack_p1_o <= nxt_local_ack[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset strobes towards the rest of the device
  // Full reset holds both resets low across the one-cycle gap before the
  // stretchers start, so the logic never sees a short release
  wire logic_hold = logic_active || req_logic || req_full || full_req_ff;
  wire video_hold = video_active || req_video || req_full || full_req_ff;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      logic_reset_n_o <= 1'b0;
      video_reset_n_o <= 1'b0;
      restore_defaults_o <= 1'b0;
      strap_reload_o <= 1'b0;
    end else begin
      logic_reset_n_o <= !logic_hold;
      video_reset_n_o <= !video_hold;
      // Listed registers elsewhere restore on these strobes
      restore_defaults_o <= req_logic;
      strap_reload_o <= req_logic || full_req_ff;
    end
  end
endmodule // srcfg_regs
`default_nettype wire

// File: sim/srcfg_regs_assertions.sv
// Checker for the reset and configuration register bank.
// Bound to srcfg_regs; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module srcfg_regs_assertions (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic second_port_select_i,
  input wire logic remote_wr_p0_i,
  input wire logic remote_tgt_is_deser_i,
  input wire logic remote_ack_p0_i,
  input wire logic crc_check_en_o,
  input wire logic autoack_p0_o,
  input wire logic autoack_p1_o,
  input wire logic local_ack_p0_o,
  input wire logic logic_reset_n_o,
  input wire logic video_reset_n_o,
  input wire logic strap_reload_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire rst_wr = wr_en_i && addr_i == 8'h01;
  wire cfg_wr = wr_en_i && addr_i == 8'h03;
  property p_full; rst_wr && wdata_i[1] |=> !logic_reset_n_o && !video_reset_n_o; endproperty
  a_full: assert property (p_full) else $error("full reset missing");
  property p_logic; rst_wr && wdata_i[0] |=> !logic_reset_n_o; endproperty
  a_logic: assert property (p_logic) else $error("logic reset missing");
  property p_strap; rst_wr && wdata_i[0] |-> ##[1:3] strap_reload_o; endproperty
  a_strap: assert property (p_strap) else $error("no strap reload");
  property p_video; rst_wr && wdata_i == 8'h10 |=> !video_reset_n_o && logic_reset_n_o; endproperty
  a_video: assert property (p_video) else $error("video reset wrong");
  property p_crc; cfg_wr && !second_port_select_i |-> ##2 crc_check_en_o == $past(wdata_i[7], 2); endproperty
  a_crc: assert property (p_crc) else $error("crc enable wrong");
  property p_port1; cfg_wr && second_port_select_i |-> ##2 autoack_p1_o == $past(wdata_i[5], 2); endproperty
  a_port1: assert property (p_port1) else $error("port1 copy wrong");
  property p_auto; remote_wr_p0_i && autoack_p0_o && remote_tgt_is_deser_i |=> local_ack_p0_o; endproperty
  a_auto: assert property (p_auto) else $error("no auto ack");
  property p_fwd; remote_wr_p0_i && !autoack_p0_o |=> local_ack_p0_o == $past(remote_ack_p0_i); endproperty
  a_fwd: assert property (p_fwd) else $error("remote ack not passed");
  property p_rsvd; rd_en_i && addr_i == 8'h01 |=> rdata_o == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reset reg nonzero");
  c_full: cover property (rst_wr && wdata_i[1]);
  c_auto: cover property (remote_wr_p0_i && autoack_p0_o);
  c_port1: cover property (cfg_wr && second_port_select_i);
endmodule // srcfg_regs_assertions
bind srcfg_regs srcfg_regs_assertions u_srcfg_regs_assertions (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i),
  .second_port_select_i(second_port_select_i),
  .remote_wr_p0_i(remote_wr_p0_i),
  .remote_tgt_is_deser_i(remote_tgt_is_deser_i),
  .remote_ack_p0_i(remote_ack_p0_i),
  .crc_check_en_o(crc_check_en_o),
  .autoack_p0_o(autoack_p0_o),
  .autoack_p1_o(autoack_p1_o),
  .local_ack_p0_o(local_ack_p0_o),
  .logic_reset_n_o(logic_reset_n_o),
  .video_reset_n_o(video_reset_n_o),
  .strap_reload_o(strap_reload_o),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o)
);
`default_nettype wire

// File: sim/srcfg_far_model.sv
// Remote target answering forwarded writes on both ports.
// Refuses while nack_i is high.
`timescale 1ns/1ns
`default_nettype none
module srcfg_far_model (
  input wire logic clk_sys_i,
  input wire logic nack_i,
  output logic ack_o
);
  // Registered answer, one cycle slow like a real remote
  always @(posedge clk_sys_i) ack_o <= !nack_i;
endmodule // srcfg_far_model
`default_nettype wire

// File: sim/serializer_reset_and_i2c_config_tb_top.sv
// Testbench for srcfg_regs: access, self-clearing resets, ack steering.
// Uses the far-side model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module serializer_reset_and_i2c_config_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, sps = 0, pa = 0, rw = 0, ds = 0, nack = 0;
  logic [7:0] addr = 0, wd = 0;
  wire [7:0] rdata;
  wire crc, ap0, ap1, la0, la1, lrn, vrn, rdef, srl, ack;
  int fail_count = 0, num_checks = 0;
  srcfg_regs #(.RST_PULSE_CYC(4)) u_srcfg_regs (.clk_sys_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wd),
    .wr_en_i(wr), .rd_en_i(rd), .second_port_select_i(sps), .pass_all_p0_i(pa), .pass_all_p1_i(pa),
    .remote_wr_p0_i(rw), .remote_wr_p1_i(rw), .remote_tgt_is_deser_i(ds), .remote_ack_p0_i(ack),
    .remote_ack_p1_i(ack), .rdata_o(rdata), .crc_check_en_o(crc), .autoack_p0_o(ap0), .autoack_p1_o(ap1),
    .local_ack_p0_o(la0), .local_ack_p1_o(la1), .logic_reset_n_o(lrn), .video_reset_n_o(vrn),
    .restore_defaults_o(rdef), .strap_reload_o(srl));
  srcfg_far_model u_srcfg_far_model (.clk_sys_i(clk), .nack_i(nack), .ack_o(ack));
  initial forever #2 clk = !clk;
  task ck(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, d);
    @(negedge clk);
    {addr, wd, wr, rd} = {a, d, w, !w};
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  task t_regs;
    acc(0, 8'h03, 0); ck(rdata, 8'h92);
    acc(1, 8'h03, 8'hFF); acc(0, 8'h03, 0); ck(rdata, 8'hBF);
    acc(1, 8'h01, 8'hEC); acc(0, 8'h01, 0); ck(rdata, 8'h00);
    acc(1, 8'h03, 8'h20); @(negedge clk); ck({7'h0, crc}, 8'h00);
    $display("t_regs done");
  endtask
  task t_ack;
    {nack, rw, ds} = 3'b111;
    repeat (2) @(negedge clk); ck({7'h0, la0}, 8'h01);
    ds = 0;
    @(negedge clk); ck({7'h0, la0}, 8'h00);
    pa = 1;
    @(negedge clk); ck({7'h0, la0}, 8'h01);
    sps = 1;
    acc(1, 8'h03, 8'h00); @(negedge clk); ck({6'h0, ap0, ap1}, 8'h02);
    ck({7'h0, la1}, 8'h00);
    {nack, sps} = 2'b00;
    acc(1, 8'h03, 8'h80); repeat (2) @(negedge clk); ck({7'h0, la0}, 8'h01);
    nack = 1;
    repeat (2) @(negedge clk); ck({7'h0, la0}, 8'h00);
    {nack, rw, pa} = 3'b000;
    $display("t_ack done");
  endtask
  task t_rst;
    acc(1, 8'h01, 8'h01); ck({6'h0, rdef, srl}, 8'h03);
    @(negedge clk); ck({7'h0, lrn}, 8'h00);
    repeat (8) @(negedge clk);
    acc(0, 8'h03, 0); ck(rdata, 8'h80);
    acc(1, 8'h01, 8'h10); @(negedge clk); ck({6'h0, lrn, vrn}, 8'h02);
    repeat (8) @(negedge clk);
    acc(1, 8'h01, 8'h02); @(negedge clk); ck({5'h0, srl, lrn, vrn}, 8'h04);
    repeat (8) @(negedge clk);
    acc(1, 8'h4F, 8'h02); acc(0, 8'h4F, 0); ck(rdata, 8'h00);
    acc(0, 8'h03, 0); ck({rdata[7:1], lrn}, 8'h93);
    $display("t_rst done");
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    t_regs;
    t_ack;
    t_rst;
    test_done;
  end
endmodule // serializer_reset_and_i2c_config_tb_top
`default_nettype wire
